/* File: design/psa_address_unit.sv */
// address unit: working registers, operand addressing, program space access
// assumes core, program memory and apb master share clk; memory data is
// valid in the cycle after the one in which progRd is high
`timescale 1ns/10ps
module psa_address_unit #(
  parameter int NUM_WREG = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // core request and answer
  input wire logic reqValid,
  input wire psa_pkg::psa_req_t req,
  output logic busy,
  output logic respValid,
  output psa_pkg::psa_resp_t resp,
  // program memory array
  output logic progRd,
  output logic [23:0] progAddr,
  output logic progCfg,
  input wire logic [23:0] progRdata
);
  typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_DATA} psa_state_t;
  localparam logic [23:0] PC_STEP_W = psa_pkg::PC_STEP;

  psa_state_t state_q;
  logic [15:0] wreg_q [NUM_WREG];
  logic [7:0] tablePage_q;
  logic [7:0] visPage_q;
  logic remapEn_q;
  logic roFault_q;
  logic lastRemap_q;
  logic lastCfg_q;
  logic busy_q;
  logic respValid_q;
  psa_pkg::psa_resp_t resp_q;
  logic progRd_q;
  logic [23:0] progAddr_q;
  logic progCfg_q;
  logic pendHigh_q;
  logic pendByte_q;
  logic pendSel_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  logic take;
  logic [15:0] litExt;
  logic [15:0] step;
  logic [15:0] baseVal;
  logic [15:0] eaSrc, eaDst, newSrc, newDst;
  logic wrSrc, wrDst, memSrc, memDst;
  logic ptrKind, isTable, isRemapRd, isRemapWr, needsProg;
  logic [23:0] progAddr_d;
  logic [15:0] fmtData;
  logic apbAcc, apbWr, apbRdAnswer;
  logic [31:0] rdData;
  logic rdHit;

  // operand addressing
  assign take = reqValid && !busy_q;
  assign litExt = psa_pkg::lit_value(req.literal, req.litWidth);
  assign baseVal = wreg_q[req.baseIdx];

  always_comb begin
    if (req.modDown) begin
      step = req.byteMode ? psa_pkg::STEP_BYTE_DEC : psa_pkg::STEP_WORD_DEC;
    end else begin
      step = req.byteMode ? psa_pkg::STEP_BYTE_INC : psa_pkg::STEP_WORD_INC;
    end
  end

  psa_ea_calc srcCalc (
    .mode(req.srcMode),
    .ptrVal(wreg_q[req.srcIdx]),
    .baseVal(baseVal),
    .litVal(litExt),
    .step(step),
    .ea(eaSrc),
    .newPtr(newSrc),
    .ptrWrite(wrSrc),
    .memAccess(memSrc)
  );

  psa_ea_calc dstCalc (
    .mode(req.dstMode),
    .ptrVal(wreg_q[req.dstIdx]),
    .baseVal(baseVal),
    .litVal(litExt),
    .step(step),
    .ea(eaDst),
    .newPtr(newDst),
    .ptrWrite(wrDst),
    .memAccess(memDst)
  );

  assign isTable = (req.kind == psa_pkg::KIND_TBL_LOW) ||
                   (req.kind == psa_pkg::KIND_TBL_HIGH);
  assign ptrKind = (req.kind == psa_pkg::KIND_DATA) || isTable;
  // remap is only seen by plain data accesses (reads redirected, writes faulted), never during table ops
  assign isRemapRd = (req.kind == psa_pkg::KIND_DATA) && memSrc &&
                     eaSrc[15] && remapEn_q && !req.isWrite;
  assign isRemapWr = (req.kind == psa_pkg::KIND_DATA) && req.isWrite &&
                     memDst && eaDst[15] && remapEn_q;
  assign needsProg = isRemapRd || isTable ||
                     (req.kind == psa_pkg::KIND_FETCH);

  always_comb begin
    if (req.kind == psa_pkg::KIND_FETCH) begin
      progAddr_d = {1'b0, req.pc[22:1], 1'b0};
    end else if (isTable) begin
      progAddr_d = {tablePage_q, eaSrc};
    end else begin
      progAddr_d = {1'b0, visPage_q, eaSrc[14:0]};
    end
  end

  // sequencing
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      busy_q <= 1'b0;
      progRd_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (take && needsProg) begin
            state_q <= ST_ISSUE;
            busy_q <= 1'b1;
            progRd_q <= 1'b1;
          end
        end
        ST_ISSUE: begin
          state_q <= ST_DATA;
          progRd_q <= 1'b0;
        end
        default: begin
          state_q <= ST_IDLE;
          busy_q <= 1'b0;
        end
      endcase
    end
  end

  // program address and the shape of the pending read
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      progAddr_q <= 24'h000000;
      progCfg_q <= 1'b0;
      pendHigh_q <= 1'b0;
      pendByte_q <= 1'b0;
      pendSel_q <= 1'b0;
    end else if (take && needsProg) begin
      progAddr_q <= progAddr_d;
      progCfg_q <= isTable && tablePage_q[7];
      pendHigh_q <= req.kind == psa_pkg::KIND_TBL_HIGH;
      pendByte_q <= isTable && req.byteMode;
      pendSel_q <= req.byteSel;
    end
  end

  // remap reads are always word reads of the low half
  psa_table_format fmt (
    .progWord(progRdata),
    .highHalf(pendHigh_q),
    .byteMode(pendByte_q),
    .byteSel(pendSel_q),
    .data(fmtData)
  );

  // answer to the core
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      respValid_q <= 1'b0;
      resp_q <= '0;
    end else begin
      respValid_q <= (take && !needsProg) || (state_q == ST_DATA);
      if (state_q == ST_DATA) begin
        resp_q.data <= fmtData;
      end else if (take) begin
        resp_q.srcEa <= eaSrc;
        resp_q.dstEa <= eaDst;
        resp_q.op1 <= baseVal;
        if (req.srcMode == psa_pkg::MODE_REG) begin
          resp_q.data <= wreg_q[req.srcIdx];
        end else if (req.srcMode == psa_pkg::MODE_LITERAL) begin
          resp_q.data <= litExt;
        end else begin
          resp_q.data <= 16'h0000;
        end
        if (req.kind == psa_pkg::KIND_BRANCH) begin
          resp_q.pc <= req.pc + PC_STEP_W +
                       {{7{req.literal[15]}}, req.literal, 1'b0};
        end else begin
          resp_q.pc <= req.pc + PC_STEP_W;
        end
        resp_q.holdCount <= (req.kind == psa_pkg::KIND_IRQ_HOLD) ?
                            req.literal[13:0] : 14'h0000;
        resp_q.remapHit <= isRemapRd;
        resp_q.roFault <= isRemapWr;
      end
    end
  end

  // working registers
  // core writeback wins over an apb write in the same cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NUM_WREG; i++) begin
        wreg_q[i] <= 16'h0000;
      end
    end else begin
      if (apbWr && paddr[7:6] == psa_pkg::WREG_BANK) begin
        wreg_q[paddr[5:2]] <= pwdata[15:0];
      end
      if (take && ptrKind && wrSrc) begin
        wreg_q[req.srcIdx] <= newSrc;
      end
      if (take && ptrKind && wrDst) begin
        wreg_q[req.dstIdx] <= newDst;
      end
    end
  end

  // apb registers
  assign apbAcc = psel && penable;
  assign apbWr = apbAcc && pready_q && pwrite;
  assign apbRdAnswer = apbAcc && !pready_q;

  always_comb begin
    rdHit = 1'b1;
    rdData = 32'h00000000;
    if (paddr == psa_pkg::OFS_TABLE_PAGE) begin
      rdData = {24'h000000, tablePage_q};
    end else if (paddr == psa_pkg::OFS_VIS_PAGE) begin
      rdData = {24'h000000, visPage_q};
    end else if (paddr == psa_pkg::OFS_CTRL) begin
      rdData = {31'h00000000, remapEn_q};
    end else if (paddr == psa_pkg::OFS_STATUS) begin
      rdData = {29'h00000000, lastCfg_q, lastRemap_q, roFault_q};
    end else if (paddr == psa_pkg::OFS_LAST_PROG) begin
      rdData = {8'h00, progAddr_q};
    end else if (paddr[7:6] == psa_pkg::WREG_BANK && paddr[1:0] == 2'h0) begin
      rdData = {16'h0000, wreg_q[paddr[5:2]]};
    end else begin
      rdHit = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= apbRdAnswer;
      if (apbRdAnswer) begin
        prdata_q <= pwrite ? 32'h00000000 : rdData;
        pslverr_q <= !rdHit;
      end else begin
        pslverr_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tablePage_q <= 8'h00;
      visPage_q <= 8'h00;
      remapEn_q <= 1'b0;
    end else if (apbWr) begin
      if (paddr == psa_pkg::OFS_TABLE_PAGE) begin
        tablePage_q <= pwdata[7:0];
      end else if (paddr == psa_pkg::OFS_VIS_PAGE) begin
        visPage_q <= pwdata[7:0];
      end else if (paddr == psa_pkg::OFS_CTRL) begin
        remapEn_q <= pwdata[psa_pkg::CTRL_REMAP_BIT];
      end
    end
  end

  // sticky write-to-remap fault; a new fault beats the clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      roFault_q <= 1'b0;
      lastRemap_q <= 1'b0;
      lastCfg_q <= 1'b0;
    end else begin
      if (take && isRemapWr) begin
        roFault_q <= 1'b1;
      end else if (apbWr && paddr == psa_pkg::OFS_STATUS &&
                   pwdata[psa_pkg::STAT_FAULT_BIT]) begin
        roFault_q <= 1'b0;
      end
      if (take && needsProg) begin
        lastRemap_q <= isRemapRd;
        lastCfg_q <= isTable && tablePage_q[7];
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign busy = busy_q;
  assign respValid = respValid_q;
  assign resp = resp_q;
  assign progRd = progRd_q;
  assign progAddr = progAddr_q;
  assign progCfg = progCfg_q;

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  sequence s_prog_take;
    take && needsProg;
  endsequence
  sequence s_prog_answer;
    progRd ##1 !progRd ##1 respValid;
  endsequence

  a_prog_answer_timing: assert property (
    s_prog_take |=> s_prog_answer)
    else $error("program read answer not two cycles after issue");
  a_table_addr_form: assert property (
    take && isTable |=> progAddr == {$past(tablePage_q), $past(eaSrc)})
    else $error("table address not page above effective address");
  a_table_cfg_sel: assert property (
    take && isTable |=> progCfg == $past(tablePage_q[7]))
    else $error("configuration select does not follow page top bit");
  a_remap_addr_form: assert property (
    take && isRemapRd |=> !progAddr[23] &&
      progAddr[22:15] == $past(visPage_q) &&
      progAddr[14:0] == $past(eaSrc[14:0]))
    else $error("remap program address badly formed");
  a_fetch_even: assert property (
    take && req.kind == psa_pkg::KIND_FETCH |=> !progAddr[0] &&
      resp.pc == $past(req.pc) + PC_STEP_W)
    else $error("fetch address odd or counter step wrong");
  a_low_word_read: assert property (
    state_q == ST_DATA && !pendHigh_q && !pendByte_q |=>
      respValid && resp.data == $past(progRdata[15:0]))
    else $error("low word read not passed unchanged");
  a_phantom_zero: assert property (
    respValid && pendHigh_q && $past(state_q) == ST_DATA |->
      resp.data[15:8] == 8'h00)
    else $error("phantom byte not zero");
  a_post_mod_ea: assert property (
    take && req.srcMode == psa_pkg::MODE_POST && ptrKind |=>
      resp.srcEa == $past(wreg_q[req.srcIdx]))
    else $error("post-modified address not the old pointer");
  a_pre_mod_wb: assert property (
    take && req.srcMode == psa_pkg::MODE_PRE && ptrKind &&
      !(wrDst && req.dstIdx == req.srcIdx) |=>
      wreg_q[$past(req.srcIdx)] == resp.srcEa)
    else $error("pre-modified pointer not written back");
  a_remap_readonly: assert property (
    take && isRemapWr && state_q == ST_IDLE |=> roFault_q && !progRd)
    else $error("write to remapped space was not refused");
  a_hold_count: assert property (
    take && req.kind == psa_pkg::KIND_IRQ_HOLD |=>
      respValid && resp.holdCount == $past(req.literal[13:0]))
    else $error("hold count not taken from literal");
  a_apb_answer: assert property (
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer not one cycle into access");
endmodule

/* File: design/psa_ea_calc.sv */
// effective address for one operand from pointer, base and literal
// assumes all inputs come from registered state on the core clock
`timescale 1ns/10ps
module psa_ea_calc (
  // operand description
  input wire psa_pkg::psa_mode_t mode,
  input wire logic [15:0] ptrVal,
  input wire logic [15:0] baseVal,
  input wire logic [15:0] litVal,
  input wire logic [15:0] step,
  // results
  output logic [15:0] ea,
  output logic [15:0] newPtr,
  output logic ptrWrite,
  output logic memAccess
);
  always_comb begin
    ea = ptrVal;
    newPtr = ptrVal;
    ptrWrite = 1'b0;
    memAccess = 1'b1;
    case (mode)
      psa_pkg::MODE_FILE: ea = litVal;
      psa_pkg::MODE_REG, psa_pkg::MODE_LITERAL: begin
        ea = 16'h0000;
        memAccess = 1'b0;
      end
      psa_pkg::MODE_IND: ea = ptrVal;
      psa_pkg::MODE_POST: begin
        ea = ptrVal;
        newPtr = ptrVal + step;
        ptrWrite = 1'b1;
      end
      psa_pkg::MODE_PRE: begin
        newPtr = ptrVal + step;
        ea = ptrVal + step;
        ptrWrite = 1'b1;
      end
      psa_pkg::MODE_REG_OFF: ea = ptrVal + baseVal;
      psa_pkg::MODE_LIT_OFF: ea = ptrVal + litVal;
      default: ea = ptrVal;
    endcase
  end
endmodule

/* File: design/psa_pkg.sv */
// constants, types and helpers shared by the program space address unit
// assumes one core clock; the core and program memory share it
package psa_pkg;
  localparam int DATA_W = 16;
  localparam int PROG_W = 24;
  localparam int IDX_W = 4;
  localparam int HOLD_W = 14;
  localparam logic [7:0] OFS_TABLE_PAGE = 8'h00;
  localparam logic [7:0] OFS_VIS_PAGE = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_LAST_PROG = 8'h10;
  localparam logic [1:0] WREG_BANK = 2'h1;
  localparam int CTRL_REMAP_BIT = 0;
  localparam int STAT_FAULT_BIT = 0;
  localparam logic [15:0] STEP_BYTE_INC = 16'h0001;
  localparam logic [15:0] STEP_WORD_INC = 16'h0002;
  localparam logic [15:0] STEP_BYTE_DEC = 16'hffff;
  localparam logic [15:0] STEP_WORD_DEC = 16'hfffe;
  localparam logic [23:0] PC_STEP = 24'h000002;
  localparam logic [15:0] MASK_LIT5 = 16'h001f;
  localparam logic [15:0] MASK_LIT8 = 16'h00ff;
  localparam logic [15:0] MASK_LIT10 = 16'h03ff;

  typedef enum logic [2:0] {
    KIND_DATA, KIND_FETCH, KIND_TBL_LOW, KIND_TBL_HIGH, KIND_BRANCH,
    KIND_IRQ_HOLD
  } psa_kind_t;
  typedef enum logic [2:0] {
    MODE_FILE, MODE_REG, MODE_IND, MODE_POST, MODE_PRE, MODE_REG_OFF,
    MODE_LIT_OFF, MODE_LITERAL
  } psa_mode_t;
  typedef enum logic [1:0] {LIT_5, LIT_8, LIT_10, LIT_16} psa_litw_t;

  typedef struct packed {
    psa_kind_t kind;
    psa_mode_t srcMode;
    psa_mode_t dstMode;
    logic [IDX_W-1:0] srcIdx;
    logic [IDX_W-1:0] dstIdx;
    logic [IDX_W-1:0] baseIdx;
    logic [DATA_W-1:0] literal;
    psa_litw_t litWidth;
    logic byteMode;
    logic byteSel;
    logic modDown;
    logic isWrite;
    logic [PROG_W-1:0] pc;
  } psa_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] srcEa;
    logic [DATA_W-1:0] dstEa;
    logic [DATA_W-1:0] op1;
    logic [DATA_W-1:0] data;
    logic [PROG_W-1:0] pc;
    logic [HOLD_W-1:0] holdCount;
    logic remapHit;
    logic roFault;
  } psa_resp_t;

  function automatic logic [15:0] lit_value(logic [15:0] raw,
                                            psa_litw_t w);
    case (w)
      LIT_5: lit_value = raw & MASK_LIT5;
      LIT_8: lit_value = raw & MASK_LIT8;
      LIT_10: lit_value = raw & MASK_LIT10;
      default: lit_value = raw;
    endcase
  endfunction
endpackage

/* File: design/psa_table_format.sv */
// shapes a 24-bit program word into a 16-bit data word
// assumes the word is already captured; purely combinational
`timescale 1ns/10ps
module psa_table_format (
  // program word and access shape
  input wire logic [23:0] progWord,
  input wire logic highHalf,
  input wire logic byteMode,
  input wire logic byteSel,
  // data side
  output logic [15:0] data
);
  always_comb begin
    data = progWord[15:0];
    if (highHalf) begin
      // upper data byte of the high half does not exist: always zero
      if (byteMode && byteSel) begin
        data = 16'h0000;
      end else begin
        data = {8'h00, progWord[23:16]};
      end
    end else if (byteMode) begin
      if (byteSel) begin
        data = {8'h00, progWord[15:8]};
      end else begin
        data = {8'h00, progWord[7:0]};
      end
    end
  end
endmodule

/* File: test/program_space_address_unit_bench.sv */
// self-checking bench for the program space address unit
// assumes apb master, core and program memory share one 10 MHz clock
`timescale 1ns/10ps
module program_space_address_unit_bench;
  logic clk, resetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic reqValid, busy, respValid, progRd, progCfg;
  psa_pkg::psa_req_t req, r;
  psa_pkg::psa_resp_t resp, rs;
  logic [23:0] progAddr, progRdata, pw;
  int errors = 0;
  int numChecks = 0;
  int cycles = 0;
  int progReads = 0;

  psa_address_unit psa_address_unit_inst (.clk(clk), .resetn(resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reqValid(reqValid), .req(req), .busy(busy), .respValid(respValid),
    .resp(resp), .progRd(progRd), .progAddr(progAddr), .progCfg(progCfg),
    .progRdata(progRdata));
  psa_prog_mem_model psa_prog_mem_model_inst (.clk(clk), .progRd(progRd),
    .progAddr(progAddr), .progCfg(progCfg), .progRdata(progRdata));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    if (progRd === 1'b1) progReads <= progReads + 1;
    cycles = cycles + 1;
    // a hang is cut short and counted as a mismatch
    if (cycles == 4000) begin
      errors++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", numChecks, errors);
    if (errors == 0 && numChecks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(string nm, logic [31:0] exp, logic [31:0] got);
    numChecks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one apb transfer; request held until pready is sampled high
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 10);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    check("pready", 32'h1, {31'h0, pready});
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
    check("write error", 32'h0, {31'h0, e});
  endtask
  task automatic rdc(string nm, logic [7:0] a, logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    check(nm, exp, q);
  endtask
  // one core request from r; answer latency and program reads judged
  task automatic core(int lat, int reads);
    int n = 0;
    int p0 = progReads;
    int b = 0;
    @(posedge clk);
    reqValid <= 1'b1;
    req <= r;
    do begin
      @(posedge clk);
      n++;
    end while (busy !== 1'b0 && n < 10);
    reqValid <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (busy === 1'b1) b++;
    end while (respValid !== 1'b1 && n < 10);
    rs = resp;
    check("latency", lat, n);
    check("busy cycles", 2 * reads, b);
    check("program reads", reads, progReads - p0);
  endtask
  task automatic ea_case(psa_pkg::psa_mode_t m, logic dn, logic [15:0] exp);
    r.srcMode = m;
    r.modDown = dn;
    core(1, 0);
    check("source ea", {16'h0, exp}, {16'h0, rs.srcEa});
    check("operand one", 32'h10, {16'h0, rs.op1});
  endtask

  task automatic t_regs();
    logic [31:0] q;
    logic e;
    wr(8'h44, 32'h1000);
    wr(8'h48, 32'h0010);
    wr(8'h4c, 32'h5555);
    wr(8'h50, 32'h9234);
    rdc("working reg 1", 8'h44, 32'h1000);
    rdc("table page reset", 8'h00, 32'h0);
    apb(1'b0, 8'h20, 32'h0, q, e);
    check("unmapped error", 32'h1, {31'h0, e});
    check("unmapped data", 32'h0, q);
  endtask
  task automatic t_modes();
    r = '0;
    r.kind = psa_pkg::KIND_DATA;
    r.srcIdx = 4'h1;
    r.baseIdx = 4'h2;
    r.dstMode = psa_pkg::MODE_REG;
    r.dstIdx = 4'h3;
    r.literal = 16'h01f5;
    r.litWidth = psa_pkg::LIT_10;
    ea_case(psa_pkg::MODE_IND, 1'b0, 16'h1000);
    ea_case(psa_pkg::MODE_POST, 1'b0, 16'h1000);
    rdc("post step", 8'h44, 32'h1002);
    ea_case(psa_pkg::MODE_PRE, 1'b1, 16'h1000);
    rdc("pre step", 8'h44, 32'h1000);
    ea_case(psa_pkg::MODE_REG_OFF, 1'b0, 16'h1010);
    ea_case(psa_pkg::MODE_LIT_OFF, 1'b0, 16'h11f5);
    ea_case(psa_pkg::MODE_FILE, 1'b0, 16'h01f5);
    ea_case(psa_pkg::MODE_REG, 1'b0, 16'h0000);
    check("register direct", 32'h1000, {16'h0, rs.data});
    r.srcMode = psa_pkg::MODE_IND;
    r.dstMode = psa_pkg::MODE_REG_OFF;
    core(1, 0);
    check("shared base", 32'h5565, {16'h0, rs.dstEa});
  endtask
  task automatic t_lits();
    logic [15:0] exp [4] = '{16'h001f, 16'h00ff, 16'h03ff, 16'hffff};
    r = '0;
    r.literal = 16'hffff;
    r.srcMode = psa_pkg::MODE_LITERAL;
    for (int i = 0; i < 4; i++) begin
      r.litWidth = psa_pkg::psa_litw_t'(i);
      core(1, 0);
      check("literal width", {16'h0, exp[i]}, {16'h0, rs.dstEa});
      check("literal data", {16'h0, exp[i]}, {16'h0, rs.data});
    end
  endtask
  task automatic t_branch();
    r = '0;
    r.kind = psa_pkg::KIND_BRANCH;
    r.pc = 24'h000100;
    r.literal = 16'hfffe;
    core(1, 0);
    check("branch back", 32'h0000fe, {8'h0, rs.pc});
    r.literal = 16'h7fff;
    core(1, 0);
    check("branch fwd", 32'h010100, {8'h0, rs.pc});
    r.kind = psa_pkg::KIND_IRQ_HOLD;
    r.literal = 16'hffff;
    core(1, 0);
    check("hold count", 32'h3fff, {18'h0, rs.holdCount});
    r.kind = psa_pkg::KIND_FETCH;
    r.pc = 24'h000204;
    core(3, 1);
    pw = psa_prog_mem_model_inst.word_at(24'h000204, 1'b0);
    check("fetch addr", 32'h000204, {8'h0, progAddr});
    check("fetch pc", 32'h000206, {8'h0, rs.pc});
    check("fetch data", {16'h0, pw[15:0]}, {16'h0, rs.data});
  endtask
  task automatic t_table();
    logic [31:0] exp;
    wr(8'h00, 32'h81);
    r = '0;
    r.srcMode = psa_pkg::MODE_IND;
    r.srcIdx = 4'h1;
    pw = psa_prog_mem_model_inst.word_at(24'h811000, 1'b1);
    for (int i = 0; i < 6; i++) begin
      r.kind = i < 3 ? psa_pkg::KIND_TBL_LOW : psa_pkg::KIND_TBL_HIGH;
      r.byteMode = (i % 3) != 0;
      r.byteSel = (i % 3) == 2;
      case (i)
        0: exp = {16'h0, pw[15:0]};
        1: exp = {24'h0, pw[7:0]};
        2: exp = {24'h0, pw[15:8]};
        5: exp = 32'h0;
        default: exp = {24'h0, pw[23:16]};
      endcase
      core(3, 1);
      check("table addr", 32'h811000, {8'h0, progAddr});
      check("config space", 32'h1, {31'h0, progCfg});
      check("table data", exp, {16'h0, rs.data});
    end
    wr(8'h00, 32'h01);
    core(3, 1);
    check("user space", 32'h0, {31'h0, progCfg});
  endtask
  task automatic t_remap();
    wr(8'h04, 32'h03);
    wr(8'h08, 32'h01);
    r = '0;
    r.srcMode = psa_pkg::MODE_IND;
    r.srcIdx = 4'h4;
    r.dstMode = psa_pkg::MODE_REG;
    core(3, 1);
    pw = psa_prog_mem_model_inst.word_at(24'h019234, 1'b0);
    check("remap addr", 32'h019234, {8'h0, progAddr});
    check("remap hit", 32'h1, {31'h0, rs.remapHit});
    check("remap data", {16'h0, pw[15:0]}, {16'h0, rs.data});
    r.isWrite = 1'b1;
    r.srcMode = psa_pkg::MODE_REG;
    r.dstMode = psa_pkg::MODE_IND;
    r.dstIdx = 4'h4;
    core(1, 0);
    check("remap write", 32'h1, {31'h0, rs.roFault});
    rdc("fault status", 8'h0c, 32'h3);
    wr(8'h0c, 32'h1);
    rdc("fault cleared", 8'h0c, 32'h2);
    wr(8'h08, 32'h00);
    r.isWrite = 1'b0;
    r.srcMode = psa_pkg::MODE_IND;
    r.dstMode = psa_pkg::MODE_REG;
    core(1, 0);
    check("remap off", 32'h0, {31'h0, rs.remapHit});
  endtask

  initial begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    reqValid = 1'b0;
    req = '0;
    r = '0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_regs();
    t_modes();
    t_lits();
    t_branch();
    t_table();
    t_remap();
    tally_and_finish();
  end
endmodule

/* File: test/psa_prog_mem_model.sv */
// program memory array model answering the address unit's reads
// assumes progRdata is sampled in the cycle after the progRd pulse
`timescale 1ns/10ps
module psa_prog_mem_model (
  // clock
  input wire logic clk,
  // read request
  input wire logic progRd,
  input wire logic [23:0] progAddr,
  input wire logic progCfg,
  // read data
  output logic [23:0] progRdata
);
  logic [23:0] lastQ = 24'h000000;
  logic validQ = 1'b0;
  // contents follow the address, so a wrong address shows as wrong data
  function automatic logic [23:0] word_at(logic [23:0] a, logic c);
    word_at = a ^ {c, 23'h5ac396};
  endfunction
  always @(posedge clk) begin
    validQ <= progRd;
    if (progRd === 1'b1) begin
      lastQ <= word_at(progAddr, progCfg);
    end
  end
  // outside the data cycle the bus shows the inverse, never a stale word
  assign progRdata = validQ ? lastQ : ~lastQ;
endmodule
